// *** core/doc_top.sv ***
// display inversion and image output command decoder with pixel path
module doc_top
	import doc_pkg::*;
#(
	parameter int PIX_W = DOC_PIX_W
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// host bus pins
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic command_data_select,
	input wire logic [DOC_DATA_W-1:0] data_in,
	// frame memory read side
	input wire logic [PIX_W-1:0] pixel_in,
	input wire logic pixel_valid,
	// panel side
	output logic [PIX_W-1:0] panel_pixel,
	output logic panel_valid,
	// mode flags
	output logic inversion_flag,
	output logic display_on
);
	doc_cmd_if cmd_bus ();

	logic inversion_reg;
	logic inversion_next;
	logic display_on_reg;
	logic display_on_next;
	logic [PIX_W-1:0] panel_pixel_reg;
	logic panel_valid_reg;

	doc_bus_capture u_capture (
		.clk(clk),
		.reset_n(reset_n),
		.write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n),
		.command_data_select(command_data_select),
		.data_in(data_in),
		.cmd(cmd_bus.capture)
	);

	// no mode input gates decoding, so sleep/partial/idle never block it
	always_comb begin
		inversion_next = inversion_reg;
		if (cmd_bus.cmd_valid) begin
			if (cmd_bus.opcode == DOC_OP_LEAVE_INV) begin
				inversion_next = 1'b0;
			end else if (cmd_bus.opcode == DOC_OP_ENTER_INV) begin
				inversion_next = 1'b1;
			end
		end
	end

	always_comb begin
		display_on_next = display_on_reg;
		if (cmd_bus.cmd_valid) begin
			if (cmd_bus.opcode == DOC_OP_STOP_IMG) begin
				display_on_next = 1'b0;
			end else if (cmd_bus.opcode == DOC_OP_START_IMG) begin
				display_on_next = 1'b1;
			end
		end
	end

	// each flag has its own process, so one command cannot disturb the other
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inversion_reg <= DOC_INV_RESET;
		end else begin
			inversion_reg <= inversion_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			display_on_reg <= DOC_DISP_RESET;
		end else begin
			display_on_reg <= display_on_next;
		end
	end

	// blanking drives zero while off; frame memory itself is never written here
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			panel_pixel_reg <= '0;
			panel_valid_reg <= 1'b0;
		end else begin
			panel_valid_reg <= pixel_valid && display_on_reg;
			if (!display_on_reg) begin
				panel_pixel_reg <= '0;
			end else if (inversion_reg) begin
				panel_pixel_reg <= ~pixel_in;
			end else begin
				panel_pixel_reg <= pixel_in;
			end
		end
	end

	assign panel_pixel = panel_pixel_reg;
	assign panel_valid = panel_valid_reg;
	assign inversion_flag = inversion_reg;
	assign display_on = display_on_reg;

	// decoded command strokes, one cycle wide, shared by the checks below
	logic leave_inversion_cmd;
	logic enter_inversion_cmd;
	logic stop_image_output_cmd;
	logic start_image_output_cmd;
	logic unknown_cmd;

	assign leave_inversion_cmd = cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_LEAVE_INV;
	assign enter_inversion_cmd = cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_ENTER_INV;
	assign stop_image_output_cmd = cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_STOP_IMG;
	assign start_image_output_cmd = cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_START_IMG;
	assign unknown_cmd = cmd_bus.cmd_valid && !leave_inversion_cmd && !enter_inversion_cmd
		&& !stop_image_output_cmd && !start_image_output_cmd;

	enter_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_ENTER_INV |=> inversion_reg)
		else $error("enter inversion did not set flag");
	leave_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_LEAVE_INV |=> !inversion_reg)
		else $error("leave inversion did not clear flag");
	inv_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		inversion_reg && !(cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_LEAVE_INV)
		|=> inversion_reg)
		else $error("inversion cleared without leave command");
	inv_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_bus.cmd_valid && (cmd_bus.opcode == DOC_OP_ENTER_INV ||
		cmd_bus.opcode == DOC_OP_LEAVE_INV) |=> $stable(display_on_reg))
		else $error("inversion command changed display flag");
	inv_repeat_a: assert property (@(posedge clk) disable iff (!reset_n)
		inversion_reg && cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_ENTER_INV
		|=> inversion_reg && $stable(panel_valid_reg))
		else $error("repeated enter inversion had an effect");
	disp_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_STOP_IMG
		|=> !display_on_reg ##1 panel_pixel_reg == '0 && !panel_valid_reg)
		else $error("stop image did not blank panel");
	disp_on_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_START_IMG |=> display_on_reg)
		else $error("start image did not set display flag");
	disp_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_bus.cmd_valid && (cmd_bus.opcode == DOC_OP_STOP_IMG ||
		cmd_bus.opcode == DOC_OP_START_IMG) |=> $stable(inversion_reg))
		else $error("display command changed inversion flag");
	disp_repeat_a: assert property (@(posedge clk) disable iff (!reset_n)
		!display_on_reg && cmd_bus.cmd_valid && cmd_bus.opcode == DOC_OP_STOP_IMG
		|=> !display_on_reg && panel_pixel_reg == '0)
		else $error("repeated stop image had an effect");
	pixel_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
		display_on_reg && inversion_reg |=> panel_pixel_reg == ~$past(pixel_in))
		else $error("pixel not inverted");
	pixel_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
		display_on_reg && !inversion_reg |=> panel_pixel_reg == $past(pixel_in))
		else $error("pixel altered without inversion");
	reset_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> !inversion_reg && !display_on_reg && !panel_valid_reg)
		else $error("flags not cleared after reset");

	// refused strokes must leave both flags alone, and each strobe gives a single one-cycle stroke
	unknown_op_a: assert property (@(posedge clk) disable iff (!reset_n)
		unknown_cmd |=> $stable(inversion_reg) && $stable(display_on_reg))
		else $error("unknown opcode changed a flag");
	cmd_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_bus.cmd_valid |=> !cmd_bus.cmd_valid)
		else $error("one strobe gave more than one command");

	// inversion flag
	inv_stay_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		!inversion_reg && !enter_inversion_cmd |=> !inversion_reg)
		else $error("inversion set without enter command");
	leave_repeat_a: assert property (@(posedge clk) disable iff (!reset_n)
		!inversion_reg && leave_inversion_cmd
		|=> !inversion_reg && $stable(display_on_reg))
		else $error("repeated leave inversion had an effect");
	inv_while_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		!display_on_reg && enter_inversion_cmd |=> inversion_reg && !display_on_reg)
		else $error("enter inversion while blanked disturbed a flag");

	// display flag
	disp_stay_on_a: assert property (@(posedge clk) disable iff (!reset_n)
		display_on_reg && !stop_image_output_cmd |=> display_on_reg)
		else $error("display cleared without stop command");
	disp_stay_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		!display_on_reg && !start_image_output_cmd |=> !display_on_reg)
		else $error("display set without start command");
	start_repeat_a: assert property (@(posedge clk) disable iff (!reset_n)
		display_on_reg && start_image_output_cmd
		|=> display_on_reg && $stable(inversion_reg))
		else $error("repeated start image had an effect");

	// pixel path
	blank_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		!display_on_reg |=> panel_pixel_reg == '0 && !panel_valid_reg)
		else $error("panel not blank while display off");
	valid_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
		display_on_reg |=> panel_valid_reg == $past(pixel_valid))
		else $error("panel valid does not follow pixel valid");
endmodule : doc_top

// *** core/doc_pkg.sv ***
// constants for the display output control command block
package doc_pkg;
	localparam int DOC_DATA_W = 16;
	localparam int DOC_OP_W = 8;
	localparam int DOC_PIX_W = 18;
	localparam logic [7:0] DOC_OP_LEAVE_INV = 8'h20;
	localparam logic [7:0] DOC_OP_ENTER_INV = 8'h21;
	localparam logic [7:0] DOC_OP_STOP_IMG = 8'h28;
	localparam logic [7:0] DOC_OP_START_IMG = 8'h29;
	localparam logic DOC_INV_RESET = 1'b0;
	localparam logic DOC_DISP_RESET = 1'b0;
	localparam int DOC_SYNC_STAGES = 3;
endpackage : doc_pkg

// *** core/doc_cmd_if.sv ***
// command byte carrier between pin capture and decoder
interface doc_cmd_if;
	import doc_pkg::*;
	logic cmd_valid;
	logic [DOC_OP_W-1:0] opcode;
	modport capture (output cmd_valid, output opcode);
	modport decoder (input cmd_valid, input opcode);
endinterface : doc_cmd_if

// *** core/doc_bus_capture.sv ***
// host bus pin synchroniser and command byte capture
module doc_bus_capture
	import doc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// host bus pins
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic command_data_select,
	input wire logic [DOC_DATA_W-1:0] data_in,
	// captured command
	doc_cmd_if.capture cmd
);
	logic [DOC_SYNC_STAGES-1:0] wr_sync_reg;
	logic [DOC_SYNC_STAGES-1:0] rd_sync_reg;
	logic [DOC_SYNC_STAGES-1:0] cds_sync_reg;
	logic [DOC_OP_W-1:0] data_s1_reg;
	logic [DOC_OP_W-1:0] data_s2_reg;
	logic [DOC_OP_W-1:0] data_s3_reg;
	logic wr_lvl_reg;
	logic rd_lvl_reg;
	logic cds_lvl_reg;
	logic wr_rise;
	logic cmd_valid_reg;
	logic [DOC_OP_W-1:0] opcode_reg;

	// upper data lines never enter the block
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_sync_reg <= '1;
			rd_sync_reg <= '1;
			cds_sync_reg <= '1;
			data_s1_reg <= '0;
			data_s2_reg <= '0;
			data_s3_reg <= '0;
		end else begin
			wr_sync_reg <= {wr_sync_reg[1:0], write_strobe_n};
			rd_sync_reg <= {rd_sync_reg[1:0], read_strobe_n};
			cds_sync_reg <= {cds_sync_reg[1:0], command_data_select};
			data_s1_reg <= data_in[DOC_OP_W-1:0];
			data_s2_reg <= data_s1_reg;
			data_s3_reg <= data_s2_reg;
		end
	end

	// a level counts only once stages two and three agree
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_lvl_reg <= 1'b1;
			rd_lvl_reg <= 1'b1;
			cds_lvl_reg <= 1'b1;
		end else begin
			if (wr_sync_reg[1] == wr_sync_reg[2]) begin
				wr_lvl_reg <= wr_sync_reg[2];
			end
			if (rd_sync_reg[1] == rd_sync_reg[2]) begin
				rd_lvl_reg <= rd_sync_reg[2];
			end
			if (cds_sync_reg[1] == cds_sync_reg[2]) begin
				cds_lvl_reg <= cds_sync_reg[2];
			end
		end
	end

	assign wr_rise = !wr_lvl_reg && wr_sync_reg[1] && wr_sync_reg[2];

	// data bytes (select high) belong to other commands and are dropped here
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmd_valid_reg <= 1'b0;
			opcode_reg <= '0;
		end else begin
			cmd_valid_reg <= wr_rise && !cds_lvl_reg && rd_lvl_reg;
			if (wr_rise) begin
				opcode_reg <= data_s3_reg;
			end
		end
	end

	assign cmd.cmd_valid = cmd_valid_reg;
	assign cmd.opcode = opcode_reg;

	cmd_frame_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_valid_reg |-> !$past(cds_lvl_reg) && $past(rd_lvl_reg) && !$past(wr_lvl_reg))
		else $error("command taken outside a command write");
	cmd_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_valid_reg |-> opcode_reg == $past(data_s3_reg))
		else $error("opcode not the byte seen at the strobe edge");
endmodule : doc_bus_capture

// *** testbench/doc_host_model.sv ***
// host processor model driving single command bytes onto the bus pins
module doc_host_model
	import doc_pkg::*;
(
	// clock
	input wire logic clk,
	// host bus pins
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic command_data_select,
	output logic [DOC_DATA_W-1:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		command_data_select = 1'b1;
		data_in = 16'h0000;
	end
	// one byte per strobe, never followed by parameter bytes
	task automatic send(input logic dcx, input logic rd, input logic [15:0] word);
		@(negedge clk);
		command_data_select = dcx;
		read_strobe_n = rd;
		data_in = word;
		write_strobe_n = 1'b0;
		repeat (4) @(negedge clk);
		write_strobe_n = 1'b1;
		// data held past the rising edge, since capture lags by the sync stages
		repeat (4) @(negedge clk);
		// released bus shows the complement so a stale byte cannot pass
		data_in = ~word;
		command_data_select = ~dcx;
		read_strobe_n = 1'b1;
	endtask
endmodule : doc_host_model

// *** testbench/doc_top_tb.sv ***
// self-checking bench for the display output control command block
module doc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import doc_pkg::*;
	typedef struct {logic dcx; logic rd; logic [7:0] op; logic inv; logic disp;} doc_row_t;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic write_strobe_n;
	logic read_strobe_n;
	logic command_data_select;
	logic [DOC_DATA_W-1:0] data_in;
	logic [DOC_PIX_W-1:0] pixel_in = 18'h0_0000;
	logic pixel_valid = 1'b1;
	logic [DOC_PIX_W-1:0] panel_pixel;
	logic [DOC_PIX_W-1:0] prev_pix;
	logic panel_valid;
	logic inversion_flag;
	logic display_on;
	int failures = 0;
	int checks_done = 0;
	// select, read strobe, opcode, then flags expected afterwards
	doc_row_t rows [11] = '{
		'{1'b0, 1'b1, 8'h21, 1'b1, 1'b0},
		'{1'b0, 1'b1, 8'h21, 1'b1, 1'b0},
		'{1'b0, 1'b1, 8'h29, 1'b1, 1'b1},
		'{1'b0, 1'b1, 8'h29, 1'b1, 1'b1},
		'{1'b1, 1'b1, 8'h20, 1'b1, 1'b1},
		'{1'b0, 1'b0, 8'h20, 1'b1, 1'b1},
		'{1'b0, 1'b1, 8'h2a, 1'b1, 1'b1},
		'{1'b0, 1'b1, 8'h20, 1'b0, 1'b1},
		'{1'b0, 1'b1, 8'h20, 1'b0, 1'b1},
		'{1'b0, 1'b1, 8'h28, 1'b0, 1'b0},
		'{1'b0, 1'b1, 8'h28, 1'b0, 1'b0}};
	always #50 clk = ~clk;
	doc_host_model doc_host_model_inst (.clk(clk), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .command_data_select(command_data_select),
		.data_in(data_in));
	doc_top doc_top_inst (.clk(clk), .reset_n(reset_n), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .command_data_select(command_data_select),
		.data_in(data_in), .pixel_in(pixel_in), .pixel_valid(pixel_valid),
		.panel_pixel(panel_pixel), .panel_valid(panel_valid),
		.inversion_flag(inversion_flag), .display_on(display_on));
	task automatic check(input logic [DOC_PIX_W-1:0] seen, input logic [DOC_PIX_W-1:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic look_at(input logic inv, input logic disp);
		check(DOC_PIX_W'(inversion_flag), DOC_PIX_W'(inv), "inversion flag");
		check(DOC_PIX_W'(display_on), DOC_PIX_W'(disp), "display on");
		check(DOC_PIX_W'(panel_valid), DOC_PIX_W'(disp), "panel valid");
		check(panel_pixel, disp ? (inv ? ~pixel_in : pixel_in) : '0, "panel pixel");
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		look_at(1'b0, 1'b0);
		$display("reset values done");
		foreach (rows[i]) begin
			pixel_in = 18'h2_5a3c + DOC_PIX_W'(i);
			doc_host_model_inst.send(rows[i].dcx, rows[i].rd, {8'ha5, rows[i].op});
			repeat (4) @(negedge clk);
			look_at(rows[i].inv, rows[i].disp);
			$display("row %0d done", i);
		end
		doc_host_model_inst.send(1'b0, 1'b1, 16'h5a21);
		doc_host_model_inst.send(1'b0, 1'b1, 16'h5a29);
		repeat (4) @(negedge clk);
		// pixel changes every cycle, so a missing stage shows at once
		for (int k = 0; k < 4; k++) begin
			prev_pix = 18'h1_0f0f << k;
			pixel_in = prev_pix;
			pixel_valid = k[0];
			@(negedge clk);
			check(panel_pixel, ~prev_pix, "inverted pixel");
			check(DOC_PIX_W'(panel_valid), DOC_PIX_W'(k[0]), "pixel valid delay");
		end
		$display("pixel latency done");
		pixel_valid = 1'b1;
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		look_at(1'b0, 1'b0);
		reset_n = 1'b1;
		@(negedge clk);
		look_at(1'b0, 1'b0);
		$display("mid-run reset done");
		close_out();
	end
	// whole sequence needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		failures++;
		close_out();
	end
endmodule : doc_top_tb
